// [hdl/iab_exec.sv]
// How it works
// - Register signed add sums both sources into the destination; special opcode, zero shift.
// - Signed adds trap when carries out of bits 30 and 31 differ.
// - A trapping signed add leaves its destination register unchanged.
// - Immediate adds sign-extend the immediate, add first source, write second field.
// - Unsigned register and immediate adds never raise the overflow exception.
// - In 64-bit mode the 32-bit sum's bit 31 fills the upper half.
// - Register conjunction ANDs both sources into the destination, no exception.
// - Immediate conjunction zero-extends the immediate; result bits above 15 are zero.
// - Branch target is delay-slot address plus sign-extended offset shifted left two.
// - False branches redirect only when the condition flag is clear.
// - True branches redirect only when the condition flag is set.
// - A taken branch redirects after exactly one delay-slot instruction.
// - Likely branches not taken nullify the delay-slot instruction.
// - The condition flag is sampled one instruction before the branch.
// - Branch encoding and variants; each may raise coprocessor unusable.
// - Register zero reads zero; writes to it have no effect.
`default_nettype none
module iab_exec
	import iab_pkg::*;
#(
	parameter int REGS = NREG
) (
	// Clock and reset.
	input wire logic i_clk,
	input wire logic i_rst_n,
	// Instruction issue.
	input wire logic i_valid,
	input wire iab_instr_t i_instr,
	input wire logic [XLEN-1:0] i_pc,
	// Core state from the same clock domain.
	input wire logic i_mode64,
	input wire logic i_cop0_usable,
	input wire logic i_cond_flag,
	// Results and events.
	output iab_wb_t o_wb,
	output iab_evt_t o_evt,
	output logic [XLEN-1:0] o_target
);
	// Sign-extends a 32-bit value to the full width.
	function automatic logic [XLEN-1:0] sx32(input logic [31:0] v);
		sx32 = {{32{v[31]}}, v};
	endfunction : sx32

	// Execute-stage registers.
	logic ex_valid_ff;
	iab_instr_t ex_ins_ff;
	logic [XLEN-1:0] ex_pc_ff;
	logic ex_cond_ff;
	logic ex_m64_ff;
	logic ex_cu_ff;
	logic samp_ff;
	logic fwd_a_ff;
	logic fwd_b_ff;
	logic [XLEN-1:0] fwd_val_ff;
	iab_slot_t slot_ff;
	iab_slot_t nxt_slot;
	logic [XLEN-1:0] pend_tgt_ff;
	iab_wb_t wb_ff;
	iab_evt_t evt_ff;
	logic [XLEN-1:0] tgt_ff;
	logic [XLEN-1:0] rd_a;
	logic [XLEN-1:0] rd_b;
	iab_wb_t wb_now;

	// Register file, read when an instruction is issued.
	iab_gpr #(
		.W(XLEN),
		.DEPTH(REGS),
		.AW(RAW)
	) u_gpr (
		.i_clk(i_clk),
		.i_re(i_valid),
		.i_raddr_a(i_instr.first_source_field),
		.i_raddr_b(i_instr.second_source_field),
		.o_rdata_a(rd_a),
		.o_rdata_b(rd_b),
		.i_we(wb_now.en),
		.i_waddr(wb_now.addr),
		.i_wdata(wb_now.data)
	);

	// Operands, bypassing a write that landed in the read cycle.
	wire logic [XLEN-1:0] opnd_a = fwd_a_ff ? fwd_val_ff : rd_a;
	wire logic [XLEN-1:0] opnd_b = fwd_b_ff ? fwd_val_ff : rd_b;
	wire logic [15:0] imm = {ex_ins_ff.rd, ex_ins_ff.sh, ex_ins_ff.fn};
	wire logic [XLEN-1:0] imm_sx = {{48{imm[15]}}, imm};
	wire logic [XLEN-1:0] imm_zx = {48'h0000_0000_0000, imm};

	// Instruction decode.
	wire logic is_spec = (ex_ins_ff.op == OP_SPECIAL) && (ex_ins_ff.sh == SHIFT_ZERO);
	wire logic is_add = is_spec && (ex_ins_ff.fn == FN_SUM_TRAP);
	wire logic is_sum_no_trap = is_spec && (ex_ins_ff.fn == FN_SUM_NOTRAP);
	wire logic is_and = is_spec && (ex_ins_ff.fn == FN_CONJ);
	wire logic is_sum_immediate_with_trap = ex_ins_ff.op == OP_SUM_IMM_TRAP;
	wire logic is_sum_immediate_no_trap = ex_ins_ff.op == OP_SUM_IMM_NOTRAP;
	wire logic is_bitwise_conjunction_immediate = ex_ins_ff.op == OP_CONJ_IMM;
	wire logic is_bc = (ex_ins_ff.op == OP_COP_ZERO)
		&& (ex_ins_ff.first_source_field == COP_BRANCH_SEL)
		&& ((ex_ins_ff.second_source_field == BR_FALSE)
		|| (ex_ins_ff.second_source_field == BR_TRUE)
		|| (ex_ins_ff.second_source_field == BR_FALSE_LIKELY)
		|| (ex_ins_ff.second_source_field == BR_TRUE_LIKELY));
	wire logic is_sum = is_add || is_sum_no_trap || is_sum_immediate_with_trap || is_sum_immediate_no_trap;
	wire logic is_reg_form = is_add || is_sum_no_trap || is_and;
	wire logic writes = is_sum || is_and || is_bitwise_conjunction_immediate;

	// Adder on the low 32 bits, with the two carries for overflow.
	wire logic [XLEN-1:0] sum_b = (is_sum_immediate_with_trap || is_sum_immediate_no_trap) ? imm_sx : opnd_b;
	wire logic [31:0] low_sum = opnd_a[30:0] + sum_b[30:0];
	wire logic [32:0] sum33 = {1'b0, opnd_a[31:0]} + {1'b0, sum_b[31:0]};
	wire logic carry30 = low_sum[31];
	wire logic carry31 = sum33[32];
	wire logic trap_ovf = (is_add || is_sum_immediate_with_trap) && (carry30 ^ carry31);

	// Sum widening depends on the mode.
	wire logic [XLEN-1:0] sum_res = ex_m64_ff ? sx32(sum33[31:0])
		: {32'h0000_0000, sum33[31:0]};
	wire logic [XLEN-1:0] and_res = opnd_a & opnd_b;
	wire logic [XLEN-1:0] bitwise_conjunction_immediate_res = opnd_a & imm_zx;
	wire logic [XLEN-1:0] result = is_sum ? sum_res : (is_bitwise_conjunction_immediate ? bitwise_conjunction_immediate_res : and_res);

	// Instruction takes effect unless it is a nullified delay slot.
	wire logic live = ex_valid_ff && (slot_ff != SLOT_NULL);
	wire logic [4:0] dest = is_reg_form ? ex_ins_ff.rd : ex_ins_ff.second_source_field;

	// Write suppressed by overflow and for register zero.
	assign wb_now.en = live && writes && !trap_ovf && (dest != REG_ZERO);
	assign wb_now.addr = dest;
	assign wb_now.data = result;

	// Branch condition and target.
	wire logic br_ok = live && (slot_ff == SLOT_NONE) && is_bc && ex_cu_ff;
	wire logic want_true = ex_ins_ff.second_source_field[0];
	wire logic likely = ex_ins_ff.second_source_field[1];
	wire logic br_taken = br_ok && (want_true ? ex_cond_ff : !ex_cond_ff);
	wire logic [XLEN-1:0] off_sx = {{46{imm[15]}}, imm, 2'b00};
	wire logic [XLEN-1:0] tgt_raw = ex_pc_ff + SLOT_STEP + off_sx;
	wire logic [XLEN-1:0] br_tgt = ex_m64_ff ? tgt_raw : sx32(tgt_raw[31:0]);
	wire logic cu_exc = live && (slot_ff == SLOT_NONE) && is_bc && !ex_cu_ff;

	// Delay-slot sequencing.
	always_comb begin
		nxt_slot = slot_ff;
		if (ex_valid_ff) begin
			case (slot_ff)
				SLOT_NONE: begin
					if (br_taken) begin
						nxt_slot = SLOT_RUN;
					end else if (br_ok && likely) begin
						nxt_slot = SLOT_NULL;
					end else begin
						nxt_slot = SLOT_NONE;
					end
				end
				SLOT_RUN: nxt_slot = SLOT_NONE;
				SLOT_NULL: nxt_slot = SLOT_NONE;
				default: nxt_slot = SLOT_NONE;
			endcase
		end
	end

	// Issue capture and the flag sample of the previous instruction.
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ex_valid_ff <= 1'b0;
			samp_ff <= 1'b0;
			ex_cond_ff <= 1'b0;
		end else begin
			ex_valid_ff <= i_valid;
			if (i_valid) begin
				ex_cond_ff <= samp_ff;
				samp_ff <= i_cond_flag;
			end
		end
	end

	// Instruction fields and bypass selection.
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ex_ins_ff <= '0;
			ex_pc_ff <= '0;
			ex_m64_ff <= 1'b0;
			ex_cu_ff <= 1'b0;
			fwd_a_ff <= 1'b0;
			fwd_b_ff <= 1'b0;
			fwd_val_ff <= '0;
		end else if (i_valid) begin
			ex_ins_ff <= i_instr;
			ex_pc_ff <= i_pc;
			ex_m64_ff <= i_mode64;
			ex_cu_ff <= i_cop0_usable;
			fwd_a_ff <= wb_now.en && (wb_now.addr == i_instr.first_source_field);
			fwd_b_ff <= wb_now.en && (wb_now.addr == i_instr.second_source_field);
			fwd_val_ff <= wb_now.data;
		end
	end

	// Slot state and the pending target.
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			slot_ff <= SLOT_NONE;
			pend_tgt_ff <= '0;
		end else begin
			slot_ff <= nxt_slot;
			if (br_taken) begin
				pend_tgt_ff <= br_tgt;
			end
		end
	end

	// Registered outputs; redirect goes with the delay slot's completion.
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			wb_ff <= '0;
			evt_ff <= '0;
			tgt_ff <= '0;
		end else begin
			wb_ff <= wb_now;
			evt_ff.ovf <= live && trap_ovf;
			evt_ff.cop_unusable <= cu_exc;
			evt_ff.redirect <= ex_valid_ff && (slot_ff == SLOT_RUN);
			evt_ff.nullified <= ex_valid_ff && (slot_ff == SLOT_NULL);
			if (ex_valid_ff && (slot_ff == SLOT_RUN)) begin
				tgt_ff <= pend_tgt_ff;
			end
		end
	end

	assign o_wb = wb_ff;
	assign o_evt = evt_ff;
	assign o_target = tgt_ff;
endmodule : iab_exec
`default_nettype wire

// [hdl/iab_pkg.sv]
`default_nettype none
package iab_pkg;
	// Widths of the data path and the register file.
	localparam int XLEN = 64;
	localparam int NREG = 32;
	localparam int RAW = 5;
	// Major opcodes.
	localparam logic [5:0] OP_SPECIAL = 6'h00;
	localparam logic [5:0] OP_SUM_IMM_TRAP = 6'h08;
	localparam logic [5:0] OP_SUM_IMM_NOTRAP = 6'h09;
	localparam logic [5:0] OP_CONJ_IMM = 6'h0c;
	localparam logic [5:0] OP_COP_ZERO = 6'h10;
	// Function codes under the special opcode.
	localparam logic [5:0] FN_SUM_TRAP = 6'h20;
	localparam logic [5:0] FN_SUM_NOTRAP = 6'h21;
	localparam logic [5:0] FN_CONJ = 6'h24;
	// Shift field value that the register forms require.
	localparam logic [4:0] SHIFT_ZERO = 5'h00;
	// Coprocessor branch selector and variant codes.
	localparam logic [4:0] COP_BRANCH_SEL = 5'h08;
	localparam logic [4:0] BR_FALSE = 5'h00;
	localparam logic [4:0] BR_TRUE = 5'h01;
	localparam logic [4:0] BR_FALSE_LIKELY = 5'h02;
	localparam logic [4:0] BR_TRUE_LIKELY = 5'h03;
	// Position of the condition flag in the status word.
	localparam int COND_HOLD_BIT = 18;
	// Distance from a branch to its delay-slot instruction, in bytes.
	localparam logic [63:0] SLOT_STEP = 64'h0000_0000_0000_0004;
	// Register index that always reads zero.
	localparam logic [4:0] REG_ZERO = 5'h00;

	// Instruction word split into its register-form fields.
	typedef struct packed {
		logic [5:0] op;
		logic [4:0] first_source_field;
		logic [4:0] second_source_field;
		logic [4:0] rd;
		logic [4:0] sh;
		logic [5:0] fn;
	} iab_instr_t;

	// Result write toward the register file.
	typedef struct packed {
		logic en;
		logic [4:0] addr;
		logic [63:0] data;
	} iab_wb_t;

	// Events reported to the rest of the core, one cycle each.
	typedef struct packed {
		logic ovf;
		logic cop_unusable;
		logic redirect;
		logic nullified;
	} iab_evt_t;

	// Delay-slot tracking states.
	typedef enum logic [2:0] {
		SLOT_NONE = 3'b001,
		SLOT_RUN = 3'b010,
		SLOT_NULL = 3'b100
	} iab_slot_t;
endpackage : iab_pkg
`default_nettype wire

// [hdl/iab_gpr.sv]
`default_nettype none
module iab_gpr #(
	parameter int W = 64,
	parameter int DEPTH = 32,
	parameter int AW = 5
) (
	// Clock.
	input wire logic i_clk,
	// Read side, two ports sharing one enable.
	input wire logic i_re,
	input wire logic [AW-1:0] i_raddr_a,
	input wire logic [AW-1:0] i_raddr_b,
	output logic [W-1:0] o_rdata_a,
	output logic [W-1:0] o_rdata_b,
	// Write side.
	input wire logic i_we,
	input wire logic [AW-1:0] i_waddr,
	input wire logic [W-1:0] i_wdata
);
	logic [W-1:0] mem [DEPTH];
	wire logic wr_ok = i_we && (i_waddr != '0);

	// Register zero is never written.
	always_ff @(posedge i_clk) begin
		if (wr_ok) begin
			mem[i_waddr] <= i_wdata;
		end
	end

	// Registered reads; register zero always returns zero.
	always_ff @(posedge i_clk) begin
		if (i_re) begin
			o_rdata_a <= (i_raddr_a == '0) ? '0 : mem[i_raddr_a];
			o_rdata_b <= (i_raddr_b == '0) ? '0 : mem[i_raddr_b];
		end
	end
endmodule : iab_gpr
`default_nettype wire

// [test/iab_exec_monitor.sv]
`default_nettype none
module iab_exec_chk
	import iab_pkg::*;
(
	// Clock, reset and issue.
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_valid,
	input wire iab_instr_t i_instr,
	input wire logic i_mode64,
	// Results.
	input wire iab_wb_t o_wb,
	input wire iab_evt_t o_evt,
	input wire logic [XLEN-1:0] o_target
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	// Flags the issue of any addition.
	wire logic is_sum = i_valid && (i_instr.op == OP_SUM_IMM_TRAP || i_instr.op == OP_SUM_IMM_NOTRAP
		|| i_instr.op == OP_SPECIAL && i_instr.fn[5:1] == 5'h10);
	ovf_no_write_a: assert property (o_evt.ovf |-> !o_wb.en) else $error("write on overflow");
	null_silent_a: assert property (o_evt.nullified |-> !o_wb.en && !o_evt.ovf && !o_evt.redirect)
		else $error("nullified slot acted");
	unusable_quiet_a: assert property (o_evt.cop_unusable |-> !o_evt.redirect && !o_evt.nullified)
		else $error("unusable branch acted");
	fixed_latency_a: assert property ((o_wb.en || o_evt.redirect) |-> $past(i_valid, 2))
		else $error("result without issue");
	no_trap_sum_a: assert property (i_valid && (i_instr.op == OP_SUM_IMM_NOTRAP
		|| i_instr.op == OP_SPECIAL && i_instr.fn == FN_SUM_NOTRAP) |-> ##2 !o_evt.ovf)
		else $error("unsigned add trapped");
	conj_imm_zext_a: assert property (i_valid && i_instr.op == OP_CONJ_IMM |-> ##2 (!o_wb.en
		|| o_wb.data[63:16] == '0 && o_wb.addr == $past(i_instr.second_source_field, 2)))
		else $error("immediate and wrong");
	sum_sext_a: assert property (is_sum && i_mode64 |-> ##2 (!o_wb.en
		|| o_wb.data[63:32] == {32{o_wb.data[31]}})) else $error("sum not extended");
	sum_narrow_a: assert property (is_sum && !i_mode64 |-> ##2 (!o_wb.en || o_wb.data[63:32] == '0))
		else $error("sum upper half set");
	target_hold_a: assert property ($changed(o_target) |-> o_evt.redirect)
		else $error("target moved");
endmodule : iab_exec_chk
bind iab_exec iab_exec_chk u_chk (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_valid(i_valid),
	.i_instr(i_instr), .i_mode64(i_mode64), .o_wb(o_wb), .o_evt(o_evt), .o_target(o_target));
`default_nettype wire

// [test/tb_top.sv]
`default_nettype none
`define CHK(nm, e, s) begin n_compared++; if ((e) !== (s)) begin mismatches++; \
	$display("BAD %s exp %h got %h", nm, e, s); end end
module tb_top;
	import iab_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic i_clk = 0, i_rst_n = 0, i_valid = 0, i_mode64 = 0, i_cop0_usable = 0, i_cond_flag = 0;
	logic pend = 0, tkn = 0, lik = 0, pf = 0;
	iab_instr_t i_instr = '0;
	logic [XLEN-1:0] i_pc = '0, o_target, btgt = '0, gpr [NREG], tgt [2] = '{'0, '0};
	iab_wb_t o_wb, ew [2] = '{'0, '0};
	iab_evt_t o_evt, ee [2] = '{'0, '0};
	int mismatches = 0, n_compared = 0, cyc = 0;
	iab_exec u_dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_valid(i_valid), .i_instr(i_instr),
		.i_pc(i_pc), .i_mode64(i_mode64), .i_cop0_usable(i_cop0_usable),
		.i_cond_flag(i_cond_flag), .o_wb(o_wb), .o_evt(o_evt), .o_target(o_target));
	// Free-running core clock.
	initial forever #25 i_clk = ~i_clk;
	// Prints the counts and the verdict.
	task automatic wrap_up();
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : wrap_up
	// Checks the instruction of two cycles ago, then issues one and models it.
	task automatic step(input logic v, input logic [31:0] w);
		iab_wb_t wb;
		iab_evt_t ev;
		logic [63:0] a, b, t;
		logic [31:0] s;
		logic sp, br;
		int k;
		@(negedge i_clk);
		`CHK("wb_en", ew[1].en, o_wb.en)
		if (ew[1].en) `CHK("wb", ew[1], o_wb)
		`CHK("evt", ee[1], o_evt)
		if (ee[1].redirect) `CHK("target", tgt[1], o_target)
		ew[1] = ew[0];
		ee[1] = ee[0];
		tgt[1] = tgt[0];
		i_valid = v;
		i_instr = w;
		i_pc = {32'($urandom), 30'($urandom), 2'h0};
		i_mode64 = 1'($urandom);
		i_cop0_usable = $urandom_range(7, 0) != 0;
		i_cond_flag = 1'($urandom);
		a = gpr[w[25:21]];
		sp = w[31:26] == OP_SPECIAL && w[10:6] == SHIFT_ZERO;
		b = sp ? gpr[w[20:16]] : w[31:26] == OP_CONJ_IMM ? {48'h0, w[15:0]} : {{48{w[15]}}, w[15:0]};
		k = sp && w[5:0] == FN_SUM_TRAP || w[31:26] == OP_SUM_IMM_TRAP ? 1
			: sp && w[5:0] == FN_SUM_NOTRAP || w[31:26] == OP_SUM_IMM_NOTRAP ? 2
			: sp && w[5:0] == FN_CONJ || w[31:26] == OP_CONJ_IMM ? 3 : 0;
		s = a[31:0] + b[31:0];
		br = w[31:21] == {OP_COP_ZERO, COP_BRANCH_SEL} && w[20:18] == 3'h0;
		ev = '0;
		ev.ovf = v && k == 1 && a[31] == b[31] && s[31] != a[31];
		wb.addr = sp ? w[15:11] : w[20:16];
		wb.en = v && k != 0 && !ev.ovf && wb.addr != REG_ZERO;
		wb.data = k == 3 ? a & b : i_mode64 ? {{32{s[31]}}, s} : {32'h0, s};
		if (v && pend && !tkn && lik) begin
			wb.en = 0;
			ev.ovf = 0;
			ev.nullified = 1;
		end
		ev.redirect = v && pend && tkn;
		tgt[0] = btgt;
		if (wb.en) gpr[wb.addr] = wb.data;
		if (v) begin
			t = i_pc + SLOT_STEP + {{46{w[15]}}, w[15:0], 2'h0};
			ev.cop_unusable = !pend && br && !i_cop0_usable;
			pend = !pend && br && i_cop0_usable;
			tkn = w[16] == pf;
			lik = w[17];
			btgt = i_mode64 ? t : {{32{t[31]}}, t[31:0]};
			pf = i_cond_flag;
		end
		ew[0] = wb;
		ee[0] = ev;
	endtask : step
	// Draws one instruction; no branch while a delay slot is due.
	function automatic logic [31:0] gen(input logic nobr);
		logic [5:0] fn [3] = '{FN_SUM_TRAP, FN_SUM_NOTRAP, FN_CONJ};
		logic [5:0] op [4] = '{OP_SUM_IMM_TRAP, OP_SUM_IMM_NOTRAP, OP_CONJ_IMM, 6'h0d};
		logic [4:0] d = 5'($urandom_range(31, 0));
		int k = $urandom_range(nobr ? 6 : 8, 0);
		if (k < 3) return {OP_SPECIAL, 5'($urandom), 5'($urandom), d,
			5'($urandom_range(15, 0) == 0), fn[k]};
		if (k < 7) return {op[k - 3], 5'($urandom), d, 16'($urandom)};
		return {OP_COP_ZERO, COP_BRANCH_SEL, 5'($urandom_range(3, 0)), 16'($urandom)};
	endfunction : gen
	// Cuts a hung run short.
	always @(posedge i_clk) begin
		cyc++;
		if (cyc == 20000) begin
			mismatches++;
			wrap_up();
		end
	end
	// Reset, register loading, random traffic, drain.
	initial begin
		void'($urandom(32'hbcc2));
		gpr[0] = '0;
		repeat (8) @(negedge i_clk);
		i_rst_n = 1;
		for (int i = 1; i < NREG; i++) begin
			step(1'b1, {OP_SUM_IMM_NOTRAP, REG_ZERO, 5'(i), 16'($urandom)});
			repeat ($urandom_range(16, 0)) step(1'b1, {OP_SPECIAL, {3{5'(i)}}, SHIFT_ZERO, FN_SUM_NOTRAP});
		end
		repeat (1500) step($urandom_range(4, 0) != 0, gen(pend));
		step(1'b0, '0);
		step(1'b0, '0);
		// Mid-run reset: register contents survive, slot and flag sampling restart.
		i_rst_n = 0;
		pend = 0;
		pf = 0;
		repeat (3) @(negedge i_clk);
		i_rst_n = 1;
		repeat (1500) step($urandom_range(4, 0) != 0, gen(pend));
		step(1'b0, '0);
		step(1'b0, '0);
		wrap_up();
	end
endmodule : tb_top
`undef CHK
`default_nettype wire
